// ### design/exec_defines.svh
/*
 * Opcode patterns, field positions, widths and reset values for the execute unit.
 * Assumes 16-bit instruction words and an 8-bit data path.
 */
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// ==========================================================
// Opcode matching
// ==========================================================
`define OP_TOGGLE_HI     4'h7
`define OP_TOGGLE_MSB    15
`define OP_TOGGLE_LSB    12
`define OP_BRANCH_HI     8'he4
`define OP_ORLIT_HI      8'h09
`define OP_BYTE_MSB      15
`define OP_BYTE_LSB      8
`define OP_ORREG_HI      6'h04
`define OP_ORREG_LSB     10

// ==========================================================
// Field positions
// ==========================================================
`define FLD_BIT_MSB      11
`define FLD_BIT_LSB      9
`define FLD_BANK         8
`define FLD_DEST         9
`define FLD_LOW_MSB      7
`define FLD_LOW_LSB      0

// ==========================================================
// Widths and reset values
// ==========================================================
`define DATA_W           8
`define ADDR_W           12
`define PC_W             21
`define ACCESS_SPLIT     8'h80
`define ACCESS_HI_BANK   4'hf
`define ACCESS_LO_BANK   4'h0
`define ZERO_BYTE        8'h00
`define ZERO_PC          21'h000000

`endif

// ### design/exec_pkg.sv
/*
 * Types shared by the execute unit and its operand address former.
 * Assumes exec_defines.svh is on the include path.
 */
`include "exec_defines.svh"
package exec_pkg;

    // ==========================================================
    // Decoded operation
    // ==========================================================
    typedef enum logic [2:0]
    {
        OPK_NONE   = 3'b000,
        OPK_TOGGLE = 3'b001,
        OPK_BRANCH = 3'b010,
        OPK_ORLIT  = 3'b011,
        OPK_ORREG  = 3'b100
    } op_kind_t;

    typedef enum logic [0:0]
    {
        ST_RUN  = 1'b0,
        ST_IDLE = 1'b1
    } exec_state_t;

    // ==========================================================
    // Data memory write request
    // ==========================================================
    typedef struct packed
    {
        logic                    we;
        logic [`ADDR_W-1:0]      addr;
        logic [`DATA_W-1:0]      data;
    } mem_wr_t;

    // ==========================================================
    // Status flags touched here
    // ==========================================================
    typedef struct packed
    {
        logic neg;
        logic zero;
    } nz_flags_t;

endpackage

// ### design/operand_addr.sv
/*
 * Forms the full data memory address of a register operand.
 * Assumes the bank select value is held elsewhere and stable for the cycle.
 */
`timescale 1ns/10ps
`include "exec_defines.svh"
module operand_addr
    import exec_pkg::*;
(
    input  wire logic [`DATA_W-1:0] i_reg_addr,
    input  wire logic               i_bank_flag,
    input  wire logic [3:0]         i_bank_select_reg,
    output logic      [`ADDR_W-1:0] o_addr
);

    // ==========================================================
    // Access bank splits into low bank and high special bank
    // ==========================================================
    always_comb
    begin
        if (i_bank_flag)
            o_addr = {i_bank_select_reg, i_reg_addr};
        else if (i_reg_addr >= `ACCESS_SPLIT)
            o_addr = {`ACCESS_HI_BANK, i_reg_addr};
        else
            o_addr = {`ACCESS_LO_BANK, i_reg_addr};
    end

endmodule

// ### design/bit_toggle_or_branch_exec.sv
/*
 * Execute stage for bit toggle, OR with literal, OR with register and branch on overflow.
 * Assumes decode presents one instruction per cycle with the register operand already read
 * from the address on O_RD_ADDR, and that the program counter given is already incremented.
 */
`timescale 1ns/10ps
`include "exec_defines.svh"

// How it works
// - Bit toggle inverts only the selected register bit, no flags, one cycle.
// - Bank flag 0 uses access bank; 1 uses bank select register.
// - Overflow branch jumps only when overflow is 1; never changes flags.
// - Taken branch loads incremented PC plus twice signed 8-bit offset.
// - Branch one cycle if not taken, two if taken with an idle cycle.
// - OR literal writes accumulator OR literal to accumulator, sets N and Z.
// - OR register ORs accumulator with register, result to register if dest bit is 1, else to accumulator, sets N and Z.
module bit_toggle_or_branch_exec
    import exec_pkg::*;
(
    input  wire logic               I_CLK,
    input  wire logic               I_RST_N,
    input  wire logic               I_INSTR_VALID,
    input  wire logic [15:0]        I_INSTR,
    input  wire logic [`PC_W-1:0]   I_PC_INC,
    input  wire logic [`DATA_W-1:0] I_REG_RDATA,
    input  wire logic [3:0]         I_BANK_SELECT_REG,
    input  wire logic               I_OVERFLOW,
    output logic      [`ADDR_W-1:0] O_RD_ADDR,
    output logic                    O_STALL,
    output logic                    O_MEM_WE,
    output logic      [`ADDR_W-1:0] O_MEM_ADDR,
    output logic      [`DATA_W-1:0] O_MEM_WDATA,
    output logic      [`DATA_W-1:0] O_ACC,
    output logic                    O_FLAG_WE,
    output logic                    O_NEG,
    output logic                    O_ZERO,
    output logic                    O_PC_LOAD,
    output logic      [`PC_W-1:0]   O_PC_TARGET
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed
    {
        exec_state_t        st;
        logic [`DATA_W-1:0] acc;
        mem_wr_t            wr;
        logic               flag_we;
        nz_flags_t          nz;
        logic               pc_load;
        logic [`PC_W-1:0]   pc_target;
    } exec_regs_t;

    exec_regs_t          regs_r;
    exec_regs_t          regs_nxt;
    op_kind_t            kind;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  or_val;
    logic [`DATA_W-1:0]  bit_mask;
    logic [`PC_W-1:0]    offset_x2;

    operand_addr u_operand_addr
    (
        .i_reg_addr        (I_INSTR[`FLD_LOW_MSB:`FLD_LOW_LSB]),
        .i_bank_flag       (I_INSTR[`FLD_BANK]),
        .i_bank_select_reg (I_BANK_SELECT_REG),
        .o_addr            (addr)
    );

    // ==========================================================
    // Decode
    // ==========================================================
    always_comb
    begin
        kind = OPK_NONE;
        if (I_INSTR[`OP_TOGGLE_MSB:`OP_TOGGLE_LSB] == `OP_TOGGLE_HI)
            kind = OPK_TOGGLE;
        else if (I_INSTR[`OP_BYTE_MSB:`OP_BYTE_LSB] == `OP_BRANCH_HI)
            kind = OPK_BRANCH;
        else if (I_INSTR[`OP_BYTE_MSB:`OP_BYTE_LSB] == `OP_ORLIT_HI)
            kind = OPK_ORLIT;
        else if (I_INSTR[`OP_BYTE_MSB:`OP_ORREG_LSB] == `OP_ORREG_HI)
            kind = OPK_ORREG;
    end

    assign bit_mask  = `DATA_W'(1) << I_INSTR[`FLD_BIT_MSB:`FLD_BIT_LSB];
    // Sign extend then double; the PC wraps modulo its width like the real counter
    assign offset_x2 = {{(`PC_W-9){I_INSTR[`FLD_LOW_MSB]}}, I_INSTR[`FLD_LOW_MSB:`FLD_LOW_LSB], 1'b0};
    assign or_val    = (kind == OPK_ORLIT) ? (regs_r.acc | I_INSTR[`FLD_LOW_MSB:`FLD_LOW_LSB])
                                           : (regs_r.acc | I_REG_RDATA);

    // ==========================================================
    // Execute
    // ==========================================================
    always_comb
    begin
        regs_nxt            = regs_r;
        regs_nxt.wr.we      = 1'b0;
        regs_nxt.flag_we    = 1'b0;
        regs_nxt.pc_load    = 1'b0;
        regs_nxt.st         = ST_RUN;
        // The idle cycle swallows the already fetched instruction behind a taken branch
        if (regs_r.st == ST_RUN && I_INSTR_VALID)
        begin
            unique case (kind)
                OPK_TOGGLE:
                begin
                    regs_nxt.wr.we   = 1'b1;
                    regs_nxt.wr.addr = addr;
                    regs_nxt.wr.data = I_REG_RDATA ^ bit_mask;
                end
                OPK_BRANCH:
                begin
                    if (I_OVERFLOW)
                    begin
                        regs_nxt.pc_load   = 1'b1;
                        regs_nxt.pc_target = I_PC_INC + offset_x2;
                        regs_nxt.st        = ST_IDLE;
                    end
                end
                OPK_ORLIT:
                begin
                    regs_nxt.acc     = or_val;
                    regs_nxt.flag_we = 1'b1;
                    regs_nxt.nz.neg  = or_val[`DATA_W-1];
                    regs_nxt.nz.zero = (or_val == `ZERO_BYTE);
                end
                OPK_ORREG:
                begin
                    regs_nxt.flag_we = 1'b1;
                    regs_nxt.nz.neg  = or_val[`DATA_W-1];
                    regs_nxt.nz.zero = (or_val == `ZERO_BYTE);
                    if (I_INSTR[`FLD_DEST])
                    begin
                        regs_nxt.wr.we   = 1'b1;
                        regs_nxt.wr.addr = addr;
                        regs_nxt.wr.data = or_val;
                    end
                    else
                        regs_nxt.acc = or_val;
                end
                OPK_NONE:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            regs_r.st        <= ST_RUN;
            regs_r.acc       <= `ZERO_BYTE;
            regs_r.wr        <= '0;
            regs_r.flag_we   <= 1'b0;
            regs_r.nz        <= '0;
            regs_r.pc_load   <= 1'b0;
            regs_r.pc_target <= `ZERO_PC;
        end
        else
            regs_r <= regs_nxt;
    end

    assign O_RD_ADDR   = addr;
    assign O_STALL     = (regs_r.st == ST_IDLE);
    assign O_MEM_WE    = regs_r.wr.we;
    assign O_MEM_ADDR  = regs_r.wr.addr;
    assign O_MEM_WDATA = regs_r.wr.data;
    assign O_ACC       = regs_r.acc;
    assign O_FLAG_WE   = regs_r.flag_we;
    assign O_NEG       = regs_r.nz.neg;
    assign O_ZERO      = regs_r.nz.zero;
    assign O_PC_LOAD   = regs_r.pc_load;
    assign O_PC_TARGET = regs_r.pc_target;

    // ==========================================================
    // Checks
    // ==========================================================
    AST_TOGGLE_ONE_BIT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_TOGGLE) |=>
        (O_MEM_WE && $countones(O_MEM_WDATA ^ $past(I_REG_RDATA)) == 1 && !O_FLAG_WE))
        else $error("Toggle did not flip exactly one bit");
    AST_BANK_SELECT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_INSTR[`FLD_BANK] |-> (O_RD_ADDR[`ADDR_W-1:`DATA_W] == I_BANK_SELECT_REG))
        else $error("Banked address does not use bank select");
    AST_NO_BRANCH_CLEAR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_BRANCH && !I_OVERFLOW) |=>
        (!O_PC_LOAD && !O_STALL && !O_FLAG_WE))
        else $error("Branch taken with overflow clear");
    AST_BRANCH_TARGET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_BRANCH && I_OVERFLOW) |=>
        (O_PC_LOAD && O_PC_TARGET == $past(I_PC_INC)
            + {{(`PC_W-9){$past(I_INSTR[`FLD_LOW_MSB])}}, $past(I_INSTR[`FLD_LOW_MSB:`FLD_LOW_LSB]), 1'b0}))
        else $error("Branch target wrong");
    AST_BRANCH_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_PC_LOAD |-> O_STALL ##1 (!O_STALL && !O_PC_LOAD && !O_MEM_WE && !O_FLAG_WE))
        else $error("Taken branch idle cycle wrong");
    AST_ORLIT_ACC: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_ORLIT) |=>
        (O_ACC == ($past(O_ACC) | $past(I_INSTR[7:0])) && O_FLAG_WE && O_ZERO == (O_ACC == 8'h00)))
        else $error("OR literal result wrong");
    AST_ORREG_FILE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_ORREG && I_INSTR[`FLD_DEST]) |=>
        (O_MEM_WE && O_MEM_WDATA == ($past(O_ACC) | $past(I_REG_RDATA)) && O_NEG == O_MEM_WDATA[7]))
        else $error("OR register file result wrong");
    AST_ORREG_ACC: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_ORREG && !I_INSTR[`FLD_DEST]) |=>
        (!O_MEM_WE && O_ACC == ($past(O_ACC) | $past(I_REG_RDATA))))
        else $error("OR register to accumulator wrong");
    AST_TOGGLE_EXACT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_TOGGLE) |=>
        (O_MEM_ADDR == $past(O_RD_ADDR) && O_MEM_WDATA ==
            ($past(I_REG_RDATA) ^ (`DATA_W'(1) << $past(I_INSTR[`FLD_BIT_MSB:`FLD_BIT_LSB])))))
        else $error("Toggle wrote the wrong bit or address");
    AST_ACCESS_BANK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !I_INSTR[`FLD_BANK] |-> (O_RD_ADDR[`ADDR_W-1:`DATA_W] ==
            (I_INSTR[`FLD_LOW_MSB] ? `ACCESS_HI_BANK : `ACCESS_LO_BANK)))
        else $error("Access bank address wrong");
    AST_ORLIT_FLAGS: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_ORLIT) |=>
        (O_NEG == O_ACC[`DATA_W-1] && !O_MEM_WE && !O_PC_LOAD))
        else $error("OR literal negative flag or side effect wrong");
    AST_ORREG_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (regs_r.st == ST_RUN && I_INSTR_VALID && kind == OPK_ORREG) |=>
        (O_FLAG_WE && O_ZERO == (($past(O_ACC) | $past(I_REG_RDATA)) == `ZERO_BYTE)))
        else $error("OR register zero flag wrong");
    AST_IGNORED_QUIET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (!I_INSTR_VALID || O_STALL) |=> (!O_MEM_WE && !O_FLAG_WE && !O_PC_LOAD && $stable(O_ACC)))
        else $error("Ignored cycle had an effect");

endmodule

// ### bench/tb.sv
/*
 * Self-checking bench for the execute stage: random and boundary words of every kind.
 * Assumes the bench stands in for decode, the status register and the data memory.
 */
`timescale 1ns/10ps
`include "exec_defines.svh"
module tb;
    // ==========================================================
    // Signals and model state
    // ==========================================================
    logic               clk;
    logic               rst_n;
    logic               instr_valid;
    logic [15:0]        instr;
    logic [`PC_W-1:0]   pc_inc;
    logic [`DATA_W-1:0] reg_rdata;
    logic [3:0]         bank_sel;
    logic               overflow;
    logic [`ADDR_W-1:0] rd_addr;
    logic               stall;
    logic               mem_we;
    logic [`ADDR_W-1:0] mem_addr;
    logic [`DATA_W-1:0] mem_wdata;
    logic [`DATA_W-1:0] acc;
    logic               flag_we;
    logic               neg;
    logic               zero;
    logic               pc_load;
    logic [`PC_W-1:0]   pc_target;
    logic [7:0]         m_acc;
    logic               m_neg;
    logic               m_zero;
    int                 mismatches;
    int                 compares;
    logic [7:0]         edge_tab [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};

    bit_toggle_or_branch_exec u_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_INSTR_VALID(instr_valid), .I_INSTR(instr),
        .I_PC_INC(pc_inc), .I_REG_RDATA(reg_rdata), .I_BANK_SELECT_REG(bank_sel),
        .I_OVERFLOW(overflow), .O_RD_ADDR(rd_addr), .O_STALL(stall), .O_MEM_WE(mem_we),
        .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata), .O_ACC(acc), .O_FLAG_WE(flag_we),
        .O_NEG(neg), .O_ZERO(zero), .O_PC_LOAD(pc_load), .O_PC_TARGET(pc_target));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // One instruction: drive after the edge, check after the next
    // ==========================================================
    // Kinds: 0 toggle, 1 branch, 2 or-literal, 3 or-register, 4 nothing valid, 5 unknown opcode
    task automatic run_one(input int kind, input bit fz);
        logic [7:0]  f;
        logic [7:0]  v;
        logic [7:0]  res;
        logic [2:0]  b;
        logic        a;
        logic        d;
        logic [11:0] ea;
        f = ($urandom % 3 == 0) ? edge_tab[$urandom % 4] : 8'($urandom);
        v = fz ? 8'h00 : 8'($urandom);
        f = fz ? 8'h00 : f;
        b = 3'($urandom);
        a = 1'($urandom);
        d = 1'($urandom);
        bank_sel = 4'($urandom);
        overflow = 1'($urandom);
        pc_inc = 21'($urandom);
        reg_rdata = v;
        instr_valid = (kind != 4);
        case (kind)
            0: instr = {4'h7, b, a, f};
            1: instr = {8'he4, f};
            2: instr = {8'h09, f};
            3: instr = {6'h04, d, a, f};
            4: instr = 16'($urandom);
            // No decoded pattern starts with f, so this word must do nothing
            default: instr = {4'hf, 12'($urandom)};
        endcase
        ea = a ? {bank_sel, f} : {(f >= 8'h80) ? 4'hf : 4'h0, f};
        #1;
        if (kind == 0 || kind == 3)
            chk(rd_addr, ea);
        @(posedge clk);
        #1;
        res = (kind == 2) ? (m_acc | f) : (m_acc | v);
        if (kind == 2 || (kind == 3 && !d))
            m_acc = res;
        if (kind == 2 || kind == 3)
        begin
            m_neg = res[7];
            m_zero = (res == 8'h00);
        end
        chk(flag_we, kind == 2 || kind == 3);
        chk(mem_we, kind == 0 || (kind == 3 && d));
        if (kind == 0)
            chk(mem_wdata, v ^ (8'h01 << b));
        if (kind == 3 && d)
            chk(mem_wdata, res);
        if (kind == 0 || (kind == 3 && d))
            chk(mem_addr, ea);
        chk(acc, m_acc);
        chk({neg, zero}, {m_neg, m_zero});
        chk(pc_load, kind == 1 && overflow);
        chk(stall, kind == 1 && overflow);
        if (kind == 1 && overflow)
        begin
            chk(pc_target, 21'(pc_inc + {{12{f[7]}}, f, 1'b0}));
            // Word offered in the idle cycle must vanish without trace
            instr = {8'h09, 8'hff};
            @(posedge clk);
            #1;
            chk(stall, 1'b0);
            chk({flag_we, pc_load, mem_we}, 3'b000);
            chk(acc, m_acc);
        end
    endtask

    task automatic do_reset(input int cycles);
        rst_n = 1'b0;
        instr_valid = 1'b0;
        repeat (cycles) @(posedge clk);
        #1;
        rst_n = 1'b1;
        m_acc = 8'h00;
        m_neg = 1'b0;
        m_zero = 1'b0;
        chk({acc, neg, zero, stall, flag_we, mem_we, pc_load}, 14'h0000);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        mismatches = 0;
        compares = 0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        pc_inc = 21'h000000;
        reg_rdata = 8'h00;
        bank_sel = 4'h0;
        overflow = 1'b0;
        void'($urandom(32'h43dc5e16));
        #1;
        do_reset(20);
        run_one(2, 1'b1);
        run_one(3, 1'b1);
        for (int i = 0; i < 800; i++)
            run_one($urandom % 6, 1'b0);
        // Second reset mid-run, then back-to-back traffic again
        do_reset(1);
        run_one(3, 1'b1);
        for (int i = 0; i < 200; i++)
            run_one($urandom % 6, 1'b0);
        stop_test();
    end
endmodule
